// >>> design/fsi_pkg.sv
// Package for the slave status-indicator block: timing constants,
// indicator state codes and carrier structs.
// Assumes a 200 MHz system clock.
package fsi_pkg;
   // Clock rate and blink timebase
   localparam int unsigned CLK_HZ = 200000000;
   localparam int unsigned BLINK_HALF_MS = 250;
   localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
   localparam int unsigned PULSE_MS = 500;
   localparam int unsigned PULSE_CYC = CLK_HZ / 1000 * PULSE_MS;
   localparam int unsigned ACT_MS = 50;
   localparam int unsigned ACT_CYC = CLK_HZ / 1000 * ACT_MS;

   // Register bus offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STAT = 4'h1;
   localparam logic [3:0] OFS_IRQ_STAT = 4'h2;
   localparam logic [3:0] OFS_IRQ_EN = 4'h3;
   localparam logic [3:0] OFS_IRQ_CLR = 4'h4;

   // Control register field positions
   localparam int CTRL_INT_ERR = 0;
   localparam int CTRL_INIT_ERR = 1;
   localparam int CTRL_CFG_BAD = 2;
   localparam int CTRL_CFG_INPHASE = 3;
   localparam int CTRL_READY = 4;
   localparam int CTRL_XCHG = 5;
   localparam int CTRL_BP_FAST = 6;
   localparam logic [7:0] CTRL_RST = 8'h00;

   // Interrupt event positions
   localparam int EV_ERR = 0;
   localparam int EV_CFG = 1;
   localparam int EV_XCHG = 2;
   localparam int EV_PWR = 3;

   // Error indicator modes, one-hot; priority order is pulse, steady, cfg, blink, off
   typedef enum logic [4:0]
   {
      FSI_ERR_OFF = 5'b00001,
      FSI_ERR_PULSE = 5'b00010,
      FSI_ERR_STEADY = 5'b00100,
      FSI_ERR_BLINK = 5'b01000,
      FSI_ERR_CFG = 5'b10000
   } fsi_err_mode_t;

   // Indicator outputs travel together
   typedef struct packed
   {
      logic supply;
      logic error;
      logic ready;
      logic exchange;
   } fsi_leds_t;

   // Register bus request
   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } fsi_req_t;
endpackage

// >>> design/fsi_indicators.sv
// Status-indicator logic of a fieldbus slave coupler.
// Assumes a 200 MHz clk_i, async active-low reset, pins on supply_ok_i
// and frame activity on fb_activity_i from outside the clock domain.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module fsi_indicators
#(
   parameter int unsigned BLINK_CYC = fsi_pkg::BLINK_HALF_CYC,
   parameter int unsigned PULSE_LEN = fsi_pkg::PULSE_CYC,
   parameter int unsigned ACT_LEN = fsi_pkg::ACT_CYC
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic supply_ok_i,
   input wire logic fb_activity_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic irq_o,
   output logic supply_indicator_o,
   output logic error_indicator_o,
   output logic ready_indicator_o,
   output logic exchange_indicator_o
);
   logic [1:0] rst_sync;
   logic rst_n;
   logic [1:0] sup_sync;
   logic [1:0] act_sync;
   logic act_q;
   logic [7:0] ctrl;
   logic [3:0] irq_stat;
   logic [3:0] irq_en;
   logic [31:0] tb_cnt;
   logic blink;
   logic [31:0] pulse_cnt;
   logic [31:0] act_cnt;
   fsi_pkg::fsi_leds_t leds;
   fsi_pkg::fsi_err_mode_t err_mode;
   fsi_pkg::fsi_leds_t next_leds;
   fsi_pkg::fsi_req_t req;
   logic act_edge;
   logic pulse_on;
   logic [3:0] events;
   logic [7:0] next_rdata;
   logic supply;
   logic wr_ctrl;
   logic wr_irq_en;
   logic wr_clr;
   logic [3:0] clr_mask;

   assign rst_n = rst_sync[1];
   assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

   // Write strobe decode for one offset, shared by every writable register
   function automatic logic wr_hit(input fsi_pkg::fsi_req_t r,
      input logic [3:0] a);
      return r.wr && (r.addr == a);
   endfunction

   // Register write selects; the clear mask is empty unless written
   assign wr_ctrl = wr_hit(req, fsi_pkg::OFS_CTRL);
   assign wr_irq_en = wr_hit(req, fsi_pkg::OFS_IRQ_EN);
   assign wr_clr = wr_hit(req, fsi_pkg::OFS_IRQ_CLR);
   assign clr_mask = wr_clr ? req.wdata[3:0] : 4'h0;

   // Reset release synchroniser
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rst_sync <= 2'h0;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end

   // Pin synchronisers and activity edge store
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sup_sync <= 2'h0;
         act_sync <= 2'h0;
         act_q <= 1'b0;
      end
      else
      begin
         sup_sync <= {sup_sync[0], supply_ok_i};
         act_sync <= {act_sync[0], fb_activity_i};
         act_q <= act_sync[1];
      end
   end

   assign supply = sup_sync[1];
   assign act_edge = act_sync[1] & ~act_q;

   // Common blink timebase
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tb_cnt <= 32'h0;
         blink <= 1'b0;
      end
      else if (tb_cnt == BLINK_CYC - 1)
      begin
         tb_cnt <= 32'h0;
         blink <= ~blink;
      end
      else
         tb_cnt <= tb_cnt + 32'h1;
   end

   // Restart pulse and activity stretch counters
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pulse_cnt <= 32'h0;
         act_cnt <= 32'h0;
      end
      else
      begin
         if (pulse_cnt != PULSE_LEN)
            pulse_cnt <= pulse_cnt + 32'h1;
         if (act_edge)
            act_cnt <= ACT_LEN;
         else if (act_cnt != 32'h0)
            act_cnt <= act_cnt - 32'h1;
      end
   end

   assign pulse_on = (pulse_cnt != PULSE_LEN);

   // Error mode priority: pulse, internal, config, init
   assign err_mode = pulse_on ? fsi_pkg::FSI_ERR_PULSE :
      ctrl[fsi_pkg::CTRL_INT_ERR] ? fsi_pkg::FSI_ERR_STEADY :
      ctrl[fsi_pkg::CTRL_CFG_BAD] ? fsi_pkg::FSI_ERR_CFG :
      ctrl[fsi_pkg::CTRL_INIT_ERR] ? fsi_pkg::FSI_ERR_BLINK :
      fsi_pkg::FSI_ERR_OFF;

   // Indicator decode
   always_comb
   begin
      next_leds.supply = supply;
      next_leds.exchange = (act_cnt != 32'h0);
      next_leds.error = 1'b0;
      next_leds.ready = 1'b0;
      unique case (err_mode)
         fsi_pkg::FSI_ERR_OFF:
         begin
            if (ctrl[fsi_pkg::CTRL_XCHG])
               next_leds.ready = ctrl[fsi_pkg::CTRL_BP_FAST];
            else if (ctrl[fsi_pkg::CTRL_READY])
               next_leds.ready = blink;
         end
         fsi_pkg::FSI_ERR_PULSE: next_leds.error = 1'b1;
         fsi_pkg::FSI_ERR_STEADY: next_leds.error = 1'b1;
         fsi_pkg::FSI_ERR_BLINK: next_leds.error = blink;
         fsi_pkg::FSI_ERR_CFG:
         begin
            next_leds.error = blink;
            next_leds.ready = ctrl[fsi_pkg::CTRL_CFG_INPHASE] ? blink
                                                              : ~blink;
         end
      endcase
   end

   assign events = {supply & ~leds.supply, act_edge,
      ctrl[fsi_pkg::CTRL_CFG_BAD], ctrl[fsi_pkg::CTRL_INT_ERR]
      | ctrl[fsi_pkg::CTRL_INIT_ERR]};

   // Read data select
   assign next_rdata = (req.addr == fsi_pkg::OFS_CTRL) ? ctrl :
      (req.addr == fsi_pkg::OFS_STAT) ? {4'h0, leds} :
      (req.addr == fsi_pkg::OFS_IRQ_STAT) ? {4'h0, irq_stat} :
      (req.addr == fsi_pkg::OFS_IRQ_EN) ? {4'h0, irq_en} : 8'h00;

   // Registers and outputs; hardware set wins over software clear
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl <= fsi_pkg::CTRL_RST;
         irq_en <= 4'h0;
         irq_stat <= 4'h0;
         rdata_o <= 8'h00;
         irq_o <= 1'b0;
         leds <= '0;
      end
      else
      begin
         if (wr_ctrl)
            ctrl <= req.wdata;
         if (wr_irq_en)
            irq_en <= req.wdata[3:0];
         irq_stat <= (irq_stat & ~clr_mask) | events;
         rdata_o <= req.rd ? next_rdata : 8'h00;
         irq_o <= |(irq_stat & irq_en);
         leds <= next_leds;
      end
   end

   assign supply_indicator_o = leds.supply;
   assign error_indicator_o = leds.error;
   assign ready_indicator_o = leds.ready;
   assign exchange_indicator_o = leds.exchange;

   // Supply indicator follows synchronised pin
   supply_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      supply_indicator_o == $past(sup_sync[1]))
      else $error("supply indicator wrong");

   // Restart pulse lit while counting; sampled reset keeps the edge of
   // release, where the indicator flop is still cleared, out of the check
   sequence s_pulse;
      pulse_on && rst_n ##1 1'b1;
   endsequence
   restart_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      s_pulse |-> error_indicator_o)
      else $error("restart pulse missing");

   // Error modes: steady, blink and both fault patterns
   internal_steady_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      !pulse_on && ctrl[0] |=> error_indicator_o)
      else $error("internal error not steady");

   init_blink_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      err_mode == fsi_pkg::FSI_ERR_BLINK |=> error_indicator_o == $past(blink))
      else $error("init error not blinking");

   cfg_alternate_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      err_mode == fsi_pkg::FSI_ERR_CFG && !ctrl[3]
      |=> error_indicator_o != ready_indicator_o)
      else $error("config fault not alternating");

   cfg_inphase_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      err_mode == fsi_pkg::FSI_ERR_CFG && ctrl[3]
      |=> error_indicator_o == ready_indicator_o)
      else $error("config fault not in phase");

   // Ready modes while no error is shown
   ready_fast_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      err_mode == fsi_pkg::FSI_ERR_OFF && ctrl[5] && ctrl[6]
      |=> ready_indicator_o)
      else $error("ready not lit in fast exchange");

   ready_slow_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      err_mode == fsi_pkg::FSI_ERR_OFF && ctrl[5] && !ctrl[6]
      |=> !ready_indicator_o)
      else $error("ready lit in slow exchange");

   ready_blink_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      err_mode == fsi_pkg::FSI_ERR_OFF && !ctrl[5] && ctrl[4]
      |=> ready_indicator_o == $past(blink))
      else $error("ready not blinking");

   // Exchange stretch follows each activity edge
   exchange_act_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      act_edge |=> ##1 exchange_indicator_o)
      else $error("exchange indicator missed activity");

   // Internal error outranks a bad configuration
   err_priority_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      ctrl[0] && ctrl[2] |=> error_indicator_o)
      else $error("error priority broken");

   // Level interrupt follows enabled status one cycle later
   irq_level_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      rst_n |=> irq_o == $past((irq_stat & irq_en) != 4'h0))
      else $error("interrupt level wrong");

   // An event in the cycle of a clear still leaves its bit set
   set_wins_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      events != 4'h0 |=> (irq_stat & $past(events)) == $past(events))
      else $error("status bit lost to clear");

   // Read data is zero outside the cycle after a read
   rdata_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      !req.rd |=> rdata_o == 8'h00)
      else $error("read data not idle");

   // Exchange indicator dark once the stretch has run out
   exchange_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      act_cnt == 32'h0 |=> !exchange_indicator_o)
      else $error("exchange indicator lit too long");

   // Error indicator dark when no error mode is active
   error_dark_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      err_mode == fsi_pkg::FSI_ERR_OFF |=> !error_indicator_o)
      else $error("error indicator lit without cause");
endmodule

// >>> verif/fsi_far_end.sv
// Far-end model: backplane supply and fieldbus frame activity.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ps
module fsi_far_end
(
   input wire logic clk_i,
   output logic supply_ok_o,
   output logic activity_o
);
   // Both lines start low
   initial
   begin
      supply_ok_o = 1'b0;
      activity_o = 1'b0;
   end
   // Supply switches just after an edge
   task automatic power(input logic on);
      @(posedge clk_i);
      supply_ok_o <= on;
   endtask
   // One frame, held long enough for the input synchroniser
   task automatic burst();
      @(posedge clk_i);
      activity_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      activity_o <= 1'b0;
   endtask
endmodule

// >>> verif/fsi_indicators_tb_top.sv
// Self-checking bench for the status-indicator block.
// Assumes shortened blink, pulse and activity counts set below.
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
begin check_count++; if ((got) !== (ex)) begin error_cnt++; \
$display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module fsi_indicators_tb_top;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] rdata_o;
   logic irq_o;
   logic sup_o;
   logic err_o;
   logic rdy_o;
   logic xch_o;
   wire logic supply_ok;
   wire logic activity;
   int error_cnt = 0;
   int check_count = 0;
   int e_hi;
   int r_hi;
   int x_hi;
   int same;

   // 200 MHz clock
   always #2.5 clk_i = ~clk_i;

   fsi_indicators #(.BLINK_CYC(4), .PULSE_LEN(8), .ACT_LEN(4)) u_dut
   (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .supply_ok_i(supply_ok),
      .fb_activity_i(activity),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .rdata_o(rdata_o),
      .irq_o(irq_o),
      .supply_indicator_o(sup_o),
      .error_indicator_o(err_o),
      .ready_indicator_o(rdy_o),
      .exchange_indicator_o(xch_o)
   );

   fsi_far_end u_far
   (
      .clk_i(clk_i),
      .supply_ok_o(supply_ok),
      .activity_o(activity)
   );

   // One-cycle register write
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   // One-cycle read, data judged in the following cycle
   task automatic rd(input logic [3:0] a, input logic [7:0] ex);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      `CHK("rdata", ex, rdata_o)
      @(posedge clk_i);
      #1;
      `CHK("rdata idle", 8'h00, rdata_o)
   endtask

   // Control write, then let the indicators settle
   task automatic setc(input logic [7:0] v);
      wr(fsi_pkg::OFS_CTRL, v);
      repeat (3) @(posedge clk_i);
   endtask

   // Counts lit cycles of the error, ready and exchange indicators over n cycles
   task automatic watch(input int n);
      e_hi = 0;
      r_hi = 0;
      x_hi = 0;
      same = 0;
      repeat (n)
      begin
         @(posedge clk_i);
         #1;
         e_hi += int'(err_o === 1'b1);
         r_hi += int'(rdy_o === 1'b1);
         x_hi += int'(xch_o === 1'b1);
         same += int'(err_o === rdy_o);
         `CHK("known", 1'b0, $isunknown({err_o, rdy_o, xch_o}))
      end
   endtask

   // Restart pulse right after reset release
   task automatic t_restart();
      `CHK("reset outs", 13'h0000, {irq_o, rdata_o, sup_o, err_o, rdy_o, xch_o})
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      watch(30);
      `CHK("pulse", 8, e_hi)
      `CHK("pulse end", 1'b0, err_o)
      $display("test restart done");
   endtask

   // Supply on and off, with its interrupt raised and cleared
   task automatic t_supply();
      wr(fsi_pkg::OFS_IRQ_EN, 8'h08);
      u_far.power(1'b1);
      repeat (6) @(posedge clk_i);
      `CHK("supply", 1'b1, sup_o)
      `CHK("irq", 1'b1, irq_o)
      rd(fsi_pkg::OFS_STAT, 8'h08);
      rd(fsi_pkg::OFS_IRQ_STAT, 8'h08);
      wr(fsi_pkg::OFS_IRQ_CLR, 8'h08);
      repeat (3) @(posedge clk_i);
      `CHK("irq clr", 1'b0, irq_o)
      u_far.power(1'b0);
      repeat (6) @(posedge clk_i);
      `CHK("supply off", 1'b0, sup_o)
      $display("test supply done");
   endtask

   // Internal error outranks ready; its interrupt stays masked
   task automatic t_internal();
      setc(8'h15);
      watch(16);
      `CHK("steady", 16, e_hi)
      `CHK("ready hidden", 0, r_hi)
      `CHK("masked", 1'b0, irq_o)
      rd(fsi_pkg::OFS_IRQ_STAT, 8'h03);
      setc(8'h00);
      wr(fsi_pkg::OFS_IRQ_CLR, 8'h0f);
      $display("test internal done");
   endtask

   // Init blink, then both bad-configuration patterns
   task automatic t_blink();
      setc(8'h02);
      watch(16);
      `CHK("init blink", 8, e_hi)
      setc(8'h04);
      watch(16);
      `CHK("cfg alt", 0, same)
      `CHK("cfg err", 8, e_hi)
      setc(8'h0c);
      watch(16);
      `CHK("cfg inphase", 16, same)
      `CHK("cfg err2", 8, e_hi)
      $display("test blink done");
   endtask

   // Ready blink, then data exchange fast and slow
   task automatic t_ready();
      setc(8'h10);
      watch(16);
      `CHK("ready blink", 8, r_hi)
      `CHK("no err", 0, e_hi)
      setc(8'h60);
      watch(8);
      `CHK("fast", 8, r_hi)
      setc(8'h20);
      watch(8);
      `CHK("slow", 0, r_hi)
      setc(8'h00);
      $display("test ready done");
   endtask

   // Activity stretch, its interrupt, an unmapped read
   task automatic t_activity();
      wr(fsi_pkg::OFS_IRQ_EN, 8'h04);
      u_far.burst();
      watch(12);
      `CHK("stretch", 4, x_hi)
      `CHK("act irq", 1'b1, irq_o)
      rd(4'h9, 8'h00);
      wr(fsi_pkg::OFS_IRQ_CLR, 8'h04);
      repeat (3) @(posedge clk_i);
      `CHK("act clr", 1'b0, irq_o)
      $display("test activity done");
   endtask

   // Counts, verdict, end of run
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (12) @(posedge clk_i);
      t_restart();
      t_supply();
      t_internal();
      t_blink();
      t_ready();
      t_activity();
      close_out();
   end

   // Watchdog
   initial
   begin
      repeat (3000) @(posedge clk_i);
      error_cnt++;
      close_out();
   end
endmodule
